// ---- design/ccr_pkg.sv ----
// Constants, reset values and helpers for the channel calibration and configuration register bank
// Functional notes
// RL1: Each channel's offset correction is a 24-bit two's complement word built from all 16 high bits and the low register's upper byte.
// RL2: Both offset correction halves reset to zero, so no offset is applied until software writes one.
// RL3: Each gain correction is a 24-bit unsigned word from 0.0 to just under 2.0, built from the high register and the low register's upper byte.
// RL4: The high gain register resets to 8000h and the low one to zero, giving unity gain.
// RL5: Bits 7 down to 0 of every low-half calibration register always read as zero.
// RL6: Configuration bits 15 down to 6 are a 10-bit two's complement phase delay in modulator clock cycles.
// RL7: Configuration bits 5 down to 3 always read as zero.
// RL8: Configuration bit 2 clear leaves the DC-block filter under the global setting, set disables it for this channel alone.
// RL9: Configuration bits 1 down to 0 pick the input: pin pair, shorted, positive DC test or negative DC test.
// RL10: The configuration register resets to zero.
// RL11: Writes into reserved bit positions are ignored so those bits keep reading zero.
package ccr_pkg;

  localparam int REG_W    = 16;
  localparam int CAL_W    = 24;
  localparam int PHASE_W  = 10;
  localparam int NUM_REGS = 7;
  localparam int IDX_W    = 6;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_A_OFS_HI  = 6'h1E;
  localparam logic [IDX_W-1:0] IDX_A_OFS_LO  = 6'h1F;
  localparam logic [IDX_W-1:0] IDX_A_GAIN_HI = 6'h20;
  localparam logic [IDX_W-1:0] IDX_A_GAIN_LO = 6'h21;
  localparam logic [IDX_W-1:0] IDX_B_CFG     = 6'h22;
  localparam logic [IDX_W-1:0] IDX_B_OFS_HI  = 6'h23;
  localparam logic [IDX_W-1:0] IDX_B_OFS_LO  = 6'h24;

  // Slot numbers inside the bank, index minus the first index
  localparam int SLOT_A_OFS_HI  = 0;
  localparam int SLOT_A_OFS_LO  = 1;
  localparam int SLOT_A_GAIN_HI = 2;
  localparam int SLOT_A_GAIN_LO = 3;
  localparam int SLOT_B_CFG     = 4;
  localparam int SLOT_B_OFS_HI  = 5;
  localparam int SLOT_B_OFS_LO  = 6;

  localparam logic [REG_W-1:0] RST_OFS_HI  = 16'h0000;
  localparam logic [REG_W-1:0] RST_OFS_LO  = 16'h0000;
  localparam logic [REG_W-1:0] RST_GAIN_HI = 16'h8000;
  localparam logic [REG_W-1:0] RST_GAIN_LO = 16'h0000;
  localparam logic [REG_W-1:0] RST_CFG     = 16'h0000;

  // Writable bits; everything else is reserved and reads zero
  localparam logic [REG_W-1:0] WMASK_HI  = 16'hFFFF;
  localparam logic [REG_W-1:0] WMASK_LO  = 16'hFF00;
  localparam logic [REG_W-1:0] WMASK_CFG = 16'hFFC7;

  // Slot 0 in the lowest position
  localparam logic [NUM_REGS-1:0][REG_W-1:0] RST_TAB = {
    RST_OFS_LO, RST_OFS_HI, RST_CFG, RST_GAIN_LO, RST_GAIN_HI, RST_OFS_LO, RST_OFS_HI};
  localparam logic [NUM_REGS-1:0][REG_W-1:0] WMASK_TAB = {
    WMASK_LO, WMASK_HI, WMASK_CFG, WMASK_LO, WMASK_HI, WMASK_LO, WMASK_HI};

  localparam int LO_FIELD_LSB = 8;
  localparam int PHASE_LSB    = 6;
  localparam int PHASE_MSB    = 15;
  localparam int DCOFF_BIT    = 2;
  localparam int SEL_LSB      = 0;
  localparam int SEL_MSB      = 1;

  localparam logic [1:0] SEL_PINS     = 2'h0;
  localparam logic [1:0] SEL_SHORTED  = 2'h1;
  localparam logic [1:0] SEL_POS_TEST = 2'h2;
  localparam logic [1:0] SEL_NEG_TEST = 2'h3;

  function automatic logic [CAL_W-1:0] cal_join(input logic [REG_W-1:0] hi, input logic [REG_W-1:0] lo);
    return {hi, lo[REG_W-1:LO_FIELD_LSB]};
  endfunction

  function automatic logic [IDX_W-1:0] idx_of(input logic [7:0] addr);
    return addr[7:2];
  endfunction

endpackage

// ---- design/ccr_field_reg.sv ----
// One 16-bit software register with a writable mask and byte strobes
`timescale 1ns/1ps
module ccr_field_reg #(
  parameter logic [15:0] RST   = 16'h0000,
  parameter logic [15:0] WMASK = 16'hFFFF
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wr_en,
  input  wire logic [1:0]  strb,
  input  wire logic [15:0] wdata,
  output logic      [15:0] q
);

  logic [15:0] q_r;
  logic [15:0] lane_m;

  assign lane_m = WMASK & {{8{strb[1]}}, {8{strb[0]}}};
  assign q      = q_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_r <= RST & WMASK; // RL2 RL4 RL10
    end else if (wr_en) begin
      q_r <= (q_r & ~lane_m) | (wdata & lane_m); // RL11
    end
  end

endmodule // ccr_field_reg

// ---- design/ccr_apb_if.sv ----
// APB slave front end: address decode, strobes and error answer
`timescale 1ns/1ps
module ccr_apb_if #(
  parameter int ADDR_W = 8
) (
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ADDR_W-1:0]             paddr,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               wr_stb,
  output logic                               setup_rd,
  output logic                               hit,
  output logic [ccr_pkg::NUM_REGS-1:0]       slot_sel
);

  logic [ccr_pkg::IDX_W-1:0] idx;
  logic [ccr_pkg::IDX_W-1:0] slot;
  logic                      access;

  assign idx    = ccr_pkg::idx_of(paddr[7:0]);
  assign slot   = idx - ccr_pkg::IDX_A_OFS_HI;
  // Misaligned or higher-page addresses are unmapped
  assign hit    = (paddr[1:0] == 2'h0) && ((paddr >> 8) == '0) &&
                  (idx >= ccr_pkg::IDX_A_OFS_HI) && (idx <= ccr_pkg::IDX_B_OFS_LO);
  assign access = psel & penable;

  // Zero wait states; read data is latched in the setup cycle
  assign pready   = access;
  assign pslverr  = access & ~hit;
  assign wr_stb   = access & pwrite & hit;
  assign setup_rd = psel & ~penable & ~pwrite;

  always_comb begin
    slot_sel = '0;
    if (hit) begin
      slot_sel[slot[2:0]] = 1'b1;
    end
  end

endmodule // ccr_apb_if

// ---- design/ccr_top.sv ----
// Calibration and configuration register bank for two converter channels
`timescale 1ns/1ps
module ccr_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ADDR_W-1:0]             paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          global_dc_filter_setting,
  output logic      [ccr_pkg::CAL_W-1:0]     chan_a_offset,
  output logic      [ccr_pkg::CAL_W-1:0]     chan_a_gain,
  output logic      [ccr_pkg::CAL_W-1:0]     chan_b_offset,
  output logic      [ccr_pkg::PHASE_W-1:0]   chan_b_phase_delay,
  output logic                               chan_b_dc_filter_off,
  output logic                               chan_b_dc_filter_active,
  output logic      [1:0]                    chan_b_input_select,
  output logic                               chan_b_sel_pins,
  output logic                               chan_b_sel_shorted,
  output logic                               chan_b_sel_pos_test,
  output logic                               chan_b_sel_neg_test
);

  logic                                             wr_stb;
  logic                                             setup_rd;
  logic                                             hit;
  logic [ccr_pkg::NUM_REGS-1:0]                     slot_sel;
  logic [ccr_pkg::NUM_REGS-1:0][ccr_pkg::REG_W-1:0] reg_q;
  logic [ccr_pkg::REG_W-1:0]                        rd_word;
  logic [31:0]                                      prdata_r;
  logic [ccr_pkg::REG_W-1:0]                        cfg;

  logic [ccr_pkg::CAL_W-1:0]   a_ofs_r;
  logic [ccr_pkg::CAL_W-1:0]   a_gain_r;
  logic [ccr_pkg::CAL_W-1:0]   b_ofs_r;
  logic [ccr_pkg::PHASE_W-1:0] b_phase_r;
  logic                        b_dcoff_r;
  logic                        b_dcact_r;
  logic [1:0]                  b_sel_r;
  logic [3:0]                  b_sel_hot_r;

  ccr_apb_if #(
    .ADDR_W (ADDR_W)
  ) u_apb (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pready   (pready),
    .pslverr  (pslverr),
    .wr_stb   (wr_stb),
    .setup_rd (setup_rd),
    .hit      (hit),
    .slot_sel (slot_sel)
  );

  // Registers are 16 bits wide, so only the two low byte lanes matter
  for (genvar i = 0; i < ccr_pkg::NUM_REGS; i++) begin : g_reg
    ccr_field_reg #(
      .RST   (ccr_pkg::RST_TAB[i]),
      .WMASK (ccr_pkg::WMASK_TAB[i])
    ) u_reg (
      .clk   (clk),
      .nrst  (nrst),
      .wr_en (wr_stb & slot_sel[i]),
      .strb  (pstrb[1:0]),
      .wdata (pwdata[ccr_pkg::REG_W-1:0]),
      .q     (reg_q[i])
    );
  end

  // Read mask keeps reserved bits at zero even if a store ever held them
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < ccr_pkg::NUM_REGS; i++) begin
      if (slot_sel[i]) begin
        rd_word = reg_q[i] & ccr_pkg::WMASK_TAB[i]; // RL5 RL7
      end
    end
  end

  // Unmapped reads return zero alongside pslverr
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_r <= hit ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;
  assign cfg    = reg_q[ccr_pkg::SLOT_B_CFG];

  // Calibration words; each half takes effect on its own write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_ofs_r  <= {ccr_pkg::RST_OFS_HI, ccr_pkg::RST_OFS_LO[ccr_pkg::REG_W-1:ccr_pkg::LO_FIELD_LSB]};
      a_gain_r <= {ccr_pkg::RST_GAIN_HI, ccr_pkg::RST_GAIN_LO[ccr_pkg::REG_W-1:ccr_pkg::LO_FIELD_LSB]};
      b_ofs_r  <= {ccr_pkg::RST_OFS_HI, ccr_pkg::RST_OFS_LO[ccr_pkg::REG_W-1:ccr_pkg::LO_FIELD_LSB]};
    end else begin
      a_ofs_r  <= ccr_pkg::cal_join(reg_q[ccr_pkg::SLOT_A_OFS_HI], reg_q[ccr_pkg::SLOT_A_OFS_LO]); // RL1
      a_gain_r <= ccr_pkg::cal_join(reg_q[ccr_pkg::SLOT_A_GAIN_HI], reg_q[ccr_pkg::SLOT_A_GAIN_LO]); // RL3
      b_ofs_r  <= ccr_pkg::cal_join(reg_q[ccr_pkg::SLOT_B_OFS_HI], reg_q[ccr_pkg::SLOT_B_OFS_LO]); // RL1
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      b_phase_r <= 10'h000;
      b_dcoff_r <= 1'b0;
      b_dcact_r <= 1'b0;
      b_sel_r   <= ccr_pkg::SEL_PINS;
    end else begin
      b_phase_r <= cfg[ccr_pkg::PHASE_MSB:ccr_pkg::PHASE_LSB]; // RL6
      b_dcoff_r <= cfg[ccr_pkg::DCOFF_BIT];
      b_dcact_r <= global_dc_filter_setting & ~cfg[ccr_pkg::DCOFF_BIT]; // RL8
      b_sel_r   <= cfg[ccr_pkg::SEL_MSB:ccr_pkg::SEL_LSB];
    end
  end

  // One-hot input routing for the front-end switch matrix
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      b_sel_hot_r <= 4'h1;
    end else begin
      case (cfg[ccr_pkg::SEL_MSB:ccr_pkg::SEL_LSB]) // RL9
        ccr_pkg::SEL_PINS:     b_sel_hot_r <= 4'h1;
        ccr_pkg::SEL_SHORTED:  b_sel_hot_r <= 4'h2;
        ccr_pkg::SEL_POS_TEST: b_sel_hot_r <= 4'h4;
        ccr_pkg::SEL_NEG_TEST: b_sel_hot_r <= 4'h8;
        default:               b_sel_hot_r <= 4'h1;
      endcase
    end
  end

  assign chan_a_offset           = a_ofs_r;
  assign chan_a_gain             = a_gain_r;
  assign chan_b_offset           = b_ofs_r;
  assign chan_b_phase_delay      = b_phase_r;
  assign chan_b_dc_filter_off    = b_dcoff_r;
  assign chan_b_dc_filter_active = b_dcact_r;
  assign chan_b_input_select     = b_sel_r;
  assign chan_b_sel_pins         = b_sel_hot_r[0];
  assign chan_b_sel_shorted      = b_sel_hot_r[1];
  assign chan_b_sel_pos_test     = b_sel_hot_r[2];
  assign chan_b_sel_neg_test     = b_sel_hot_r[3];

endmodule // ccr_top

// ---- sim/ccr_assertions.sv ----
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
module ccr_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              global_dc_filter_setting,
  input wire logic [23:0]       chan_a_offset,
  input wire logic [23:0]       chan_a_gain,
  input wire logic [9:0]        chan_b_phase_delay,
  input wire logic              chan_b_dc_filter_off,
  input wire logic              chan_b_dc_filter_active,
  input wire logic [1:0]        chan_b_input_select,
  input wire logic              chan_b_sel_pins,
  input wire logic              chan_b_sel_shorted,
  input wire logic              chan_b_sel_pos_test,
  input wire logic              chan_b_sel_neg_test
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wr_ok;
  logic rd_ok;
  // Full strobes only, partial lanes keep old bits
  assign wr_ok = psel && penable && pwrite && pstrb[1:0] == 2'h3;
  assign rd_ok = psel && penable && !pwrite;
  a_ofs_upper: assert property (
    wr_ok && paddr == 8'h78 |-> ##2 chan_a_offset[23:8] == $past(pwdata[15:0], 2)) else $error("offset high lost");
  a_ofs_lower: assert property (
    wr_ok && paddr == 8'h7C |-> ##2 chan_a_offset[7:0] == $past(pwdata[15:8], 2)) else $error("offset low lost");
  a_gain_join: assert property (
    wr_ok && paddr == 8'h80 |-> ##2 chan_a_gain[23:8] == $past(pwdata[15:0], 2)) else $error("gain high lost");
  a_phase_field: assert property (
    wr_ok && paddr == 8'h88 |-> ##2 chan_b_phase_delay == $past(pwdata[15:6], 2)) else $error("phase wrong");
  a_dc_active: assert property (
    $past(nrst) |-> chan_b_dc_filter_active == ($past(global_dc_filter_setting) && !chan_b_dc_filter_off))
    else $error("dc filter wrong");
  a_sel_onehot: assert property (
    {chan_b_sel_neg_test, chan_b_sel_pos_test, chan_b_sel_shorted, chan_b_sel_pins} == 4'h1 << chan_b_input_select)
    else $error("input select decode wrong");
  a_low_reserved: assert property (
    rd_ok && (paddr == 8'h7C || paddr == 8'h84 || paddr == 8'h90) |-> prdata[7:0] == 8'h00)
    else $error("low byte not zero");
  a_cfg_reserved: assert property (
    rd_ok && paddr == 8'h88 |-> prdata[5:3] == 3'h0) else $error("cfg reserved not zero");
  c_cfg_write: cover property (wr_ok && paddr == 8'h88);
  c_low_read: cover property (rd_ok && paddr == 8'h84);
  c_unmapped: cover property (pslverr);
endmodule // ccr_assertions

bind ccr_top ccr_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
  .global_dc_filter_setting(global_dc_filter_setting), .chan_a_offset(chan_a_offset), .chan_a_gain(chan_a_gain),
  .chan_b_phase_delay(chan_b_phase_delay), .chan_b_dc_filter_off(chan_b_dc_filter_off),
  .chan_b_dc_filter_active(chan_b_dc_filter_active), .chan_b_input_select(chan_b_input_select),
  .chan_b_sel_pins(chan_b_sel_pins), .chan_b_sel_shorted(chan_b_sel_shorted),
  .chan_b_sel_pos_test(chan_b_sel_pos_test), .chan_b_sel_neg_test(chan_b_sel_neg_test));

// ---- sim/tb_channel_calibration_config_regs.sv ----
// Register-level testbench for the calibration and configuration bank
`timescale 1ns/1ps
module tb_channel_calibration_config_regs;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err, glb;
  logic        dcoff, dcact, s0, s1, s2, s3;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] aofs, again, bofs;
  logic [9:0]  ph;
  logic [1:0]  sel;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  logic [15:0] rst_v [7] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] msk [7]   = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7, 16'hFFFF, 16'hFF00};
  ccr_top #(.ADDR_W(8)) DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_dc_filter_setting(glb), .chan_a_offset(aofs), .chan_a_gain(again), .chan_b_offset(bofs),
    .chan_b_phase_delay(ph), .chan_b_dc_filter_off(dcoff), .chan_b_dc_filter_active(dcact),
    .chan_b_input_select(sel), .chan_b_sel_pins(s0), .chan_b_sel_shorted(s1), .chan_b_sel_pos_test(s2),
    .chan_b_sel_neg_test(s3));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task results;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Upper data half set to junk, it must never reach a register
  task apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'hA5A5, d};
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads drive no byte strobes
  task rdchk(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000, 4'h0);
    chk("prdata", rd, {16'h0000, e});
  endtask
  task rst_chk;
    for (int i = 0; i < 7; i++) rdchk(8'h78 + 8'(4 * i), rst_v[i]);
    chk("gain", 32'(again), 32'h00800000);
    chk("select", 32'({s3, s2, s1, s0, sel}), 32'h4);
  endtask
  initial begin
    nrst    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    glb     = 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rst_chk();
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, 8'h78 + 8'(4 * i), 16'hFFFF, 4'hF);
      rdchk(8'h78 + 8'(4 * i), msk[i]);
    end
    apb(1'b1, 8'h78, 16'h8123, 4'hF);
    apb(1'b1, 8'h7C, 16'h45FF, 4'hF);
    apb(1'b1, 8'h80, 16'hFEDC, 4'hF);
    apb(1'b1, 8'h84, 16'hBA00, 4'hF);
    apb(1'b1, 8'h8C, 16'h7FFF, 4'hF);
    apb(1'b1, 8'h90, 16'h0111, 4'hF);
    repeat (2) @(posedge clk);
    chk("a_offset", 32'(aofs), 32'h00812345);
    chk("a_gain", 32'(again), 32'h00FEDCBA);
    chk("b_offset", 32'(bofs), 32'h007FFF01);
    // Low lane only: upper byte must survive
    apb(1'b1, 8'h78, 16'h00CC, 4'h1);
    rdchk(8'h78, 16'h81CC);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 8'h88, {10'h201 ^ 10'(k), 3'h7, k[0], 2'(k)}, 4'hF);
      glb <= k[1];
      repeat (3) @(posedge clk);
      chk("phase", 32'(ph), 32'(10'h201 ^ 10'(k)));
      chk("select", 32'(sel), 32'(k));
      chk("onehot", 32'({s3, s2, s1, s0}), 32'(4'h1 << k));
      chk("dc_off", 32'(dcoff), 32'(k[0]));
      chk("dc_active", 32'(dcact), 32'(k[1] & ~k[0]));
    end
    apb(1'b0, 8'h94, 16'h0000, 4'h0);
    chk("unmapped_err", 32'(err), 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b1, 8'h7A, 16'h1234, 4'hF);
    chk("misaligned_err", 32'(err), 32'h1);
    rdchk(8'h78, 16'h81CC);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    rst_chk();
    results();
  end
endmodule // tb_channel_calibration_config_regs
